// >>> core/rxq_pkg.sv
// Constants shared by the receive packet queue design.
`default_nettype none
package rxq_pkg;
	// ****************************************
	// Geometry
	// ****************************************
	localparam int DEPTH      = 128;
	localparam int ADDR_W     = 7;
	localparam int PTR_W      = ADDR_W + 1;
	localparam int CTRL_BYTES = 2;
	localparam int CRC_BYTES  = 4;
	localparam logic [ADDR_W-1:0] TOP_ADDR  = 7'h7F;
	localparam logic [PTR_W-1:0]  PTR_RESET = 8'h00;
	localparam logic [PTR_W-1:0]  PTR_ONE   = 8'h01;
	localparam logic [PTR_W-1:0]  PTR_TWO   = 8'h02;
	// ****************************************
	// Status byte layout
	// ****************************************
	localparam int STAT_VALID_BIT = 0;
	localparam int STAT_KIND_LSB  = 4;
	localparam int STAT_KIND_W    = 3;
	localparam logic [7:0] STAT_EMPTY = 8'h00;
	localparam logic [7:0] MAX_SIZE_RESET = 8'h80;
endpackage : rxq_pkg
`default_nettype wire

// >>> core/rxq_skid.sv
// Two-entry valid/ready buffer carrying bytes from the de-serializer.
`default_nettype none
module rxq_skid #(
	parameter int W = 8
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         srst,
	// Filling side.
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side.
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	logic [W-1:0] mem_reg [2];
	logic         rd_reg;
	logic         wr_reg;
	logic [1:0]   cnt_reg;
	logic [1:0]   cnt_next;
	logic         rdy_reg;
	logic         push;
	logic         pop;

	// Ready is registered so that it leaves the block straight from a flip-flop.
	assign in_ready  = rdy_reg;
	assign cnt_next  = cnt_reg + {1'b0, push} - {1'b0, pop};
	assign out_valid = (cnt_reg != 2'h0);
	assign out_data  = mem_reg[rd_reg];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rd_reg  <= 1'b0;
			wr_reg  <= 1'b0;
			cnt_reg <= 2'h0;
			rdy_reg <= 1'b1;
		end else begin
			if (push) begin
				wr_reg <= ~wr_reg;
			end
			if (pop) begin
				rd_reg <= ~rd_reg;
			end
			cnt_reg <= cnt_next;
			rdy_reg <= (cnt_next != 2'h2);
		end
	end
endmodule : rxq_skid
`default_nettype wire

// >>> core/rxq_ram.sv
// Byte RAM with one write port and one asynchronous read port.
`default_nettype none
module rxq_ram #(
	parameter int AW = 7
) (
	// Clock.
	input  wire logic          clk,
	// Write port.
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [7:0]    wdata,
	// Read port.
	input  wire logic [AW-1:0] raddr,
	output logic [7:0]         rdata
);
	logic [7:0] mem [2**AW];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	assign rdata = mem[raddr];
endmodule : rxq_ram
`default_nettype wire

// >>> core/pd_receive_packet_queue.sv
// Write side, pointers and destructive read of the receive packet queue.
// Contract
// (R1) Store packets in a 128-byte multi-packet FIFO.
// (R2) Status byte then count byte precede packet.
// (R3) Count includes the four CRC bytes.
// (R4) Zero status is invalid; empty reads zero.
// (R5) Status bits 6:4 hold frame start kind.
// (R6) Bit 0 valid; other bits read zero.
// (R7) SMBus layout: count first, plus one.
// (R8) At start, write pointer becomes head plus two.
// (R9) Write byte, increment pointer, wrap at top.
// (R10) Good end writes status and count at head.
// (R11) Then head takes write pointer, plus one.
// (R12) Idle without end drops the packet.
// (R13) Bad CRC drops the packet.
// (R14) Overrun: discard excess, hold write pointer.
// (R15) No room for header: overrun, store nothing.
// (R16) Oversize: discard extra, hold write pointer.
// (R17) Pointers carry wrap bit for full/empty.
// (R18) Software reads and writes all pointers. Here head1 is only readable; a load sets it to head plus one.
// (R19) Software keeps pointer and wrap coherent.
// (R20) Receiver reset set-then-clear resets pointers.
// (R21) Software uses not-empty, not status polling.
// (R22) Software reads only counted bytes.
// (R23) Reads are destructive and free space.
// (R24) Error events are sticky, software-clearable flags.
`default_nettype none
module pd_receive_packet_queue #(
	parameter int DEPTH = rxq_pkg::DEPTH
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        srst,
	// Frame events and bytes from the de-serializer.
	input  wire logic        frame_start,
	input  wire logic [2:0]  received_frame_start_kind,
	input  wire logic        byte_valid,
	output logic             byte_ready,
	input  wire logic [7:0]  byte_data,
	input  wire logic        frame_end,
	input  wire logic        crc_good,
	input  wire logic        bus_idle,
	// Configuration bits of receive_control_a.
	input  wire logic        smbus_layout,
	input  wire logic        receiver_reset,
	input  wire logic [7:0]  max_packet_size,
	// Software read port.
	input  wire logic        rd_strobe,
	output logic [7:0]       rd_data,
	output logic             not_empty,
	// Software pointer access.
	input  wire logic        ptr_load,
	input  wire logic [7:0]  ptr_load_head,
	input  wire logic [7:0]  ptr_load_cur,
	input  wire logic [7:0]  ptr_load_rd,
	output logic [7:0]       head_ptr,
	output logic [7:0]       head1_ptr,
	output logic [7:0]       cur_ptr,
	output logic [7:0]       rd_ptr,
	// Sticky error flags and their clear.
	input  wire logic [3:0]  err_clear,
	output logic [3:0]       err_flags
);
	localparam int AW = rxq_pkg::ADDR_W;
	typedef logic [rxq_pkg::PTR_W-1:0] ptr_t;

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [2:0] {
		S_IDLE   = 3'b001,
		S_DATA   = 3'b010,
		S_COUNT  = 3'b100
	} wstate_e;

	wstate_e     state_reg;
	ptr_t        head_reg, head1_reg, cur_reg, rd_reg;
	logic [7:0]  len_reg;
	logic [2:0]  kind_reg;
	logic        smb_reg;
	logic        rst_q_reg;
	logic [7:0]  rd_data_reg;
	logic [3:0]  err_reg;
	logic        ne_reg;

	// Byte path through the two-entry buffer.
	logic        b_valid;
	logic        b_ready;
	logic [7:0]  b_data;

	rxq_skid #(.W(8)) u_skid (
		.clk       (clk),
		.srst      (srst),
		.in_valid  (byte_valid),
		.in_ready  (byte_ready),
		.in_data   (byte_data),
		.out_valid (b_valid),
		.out_ready (b_ready),
		.out_data  (b_data)
	);

	// ****************************************
	// Pointer arithmetic
	// ****************************************
	// Wrap bit toggles when the address passes the top of the RAM.
	function automatic ptr_t ptr_add(input ptr_t p, input ptr_t n);
		logic [AW:0] s;
		s = {1'b0, p[AW-1:0]} + {1'b0, n[AW-1:0]};
		ptr_add = {p[AW] ^ s[AW], s[AW-1:0]}; // [R9] [R17]
	endfunction : ptr_add

	// Used bytes from read pointer up to the given write pointer.
	function automatic logic [AW:0] used(input ptr_t w, input ptr_t r);
		logic [AW:0] d;
		d = {w[AW], w[AW-1:0]} - {r[AW], r[AW-1:0]};
		used = d;
	endfunction : used

	logic [AW:0] used_head;
	logic        fifo_full, hdr_room, fifo_empty;

	assign used_head  = used(head_reg, rd_reg);
	assign fifo_full  = (cur_reg[AW-1:0] == rd_reg[AW-1:0]) && (cur_reg[AW] != rd_reg[AW]); // [R17]
	assign hdr_room   = (used_head <= (AW+1)'(DEPTH - rxq_pkg::CTRL_BYTES)); // [R15]
	assign fifo_empty = (head_reg == rd_reg); // [R17]

	// ****************************************
	// Write control
	// ****************************************
	logic        we;
	logic [AW-1:0] waddr;
	logic [7:0]  wdata, stat_byte, cnt_byte;
	logic        take_byte, oversize, rcv_reset;

	// Pointer reset is taken on the falling edge of the receiver reset bit.
	assign rcv_reset = rst_q_reg && !receiver_reset; // [R20]
	assign b_ready   = 1'b1;
	assign take_byte = (state_reg == S_DATA) && b_valid;
	assign oversize  = (len_reg >= max_packet_size); // [R16]

	always_comb begin
		stat_byte = rxq_pkg::STAT_EMPTY; // [R6]
		stat_byte[rxq_pkg::STAT_VALID_BIT] = 1'b1;
		stat_byte[rxq_pkg::STAT_KIND_LSB +: rxq_pkg::STAT_KIND_W] = kind_reg; // [R5]
		cnt_byte = smb_reg ? len_reg + 8'h01 : len_reg; // [R3] [R7]
	end

	always_comb begin
		we    = 1'b0;
		waddr = cur_reg[AW-1:0];
		wdata = b_data;
		if (state_reg == S_DATA && frame_end && crc_good) begin
			we    = 1'b1; // [R10]
			waddr = head_reg[AW-1:0];
			wdata = smb_reg ? cnt_byte : stat_byte; // [R2] [R7]
		end else if (state_reg == S_COUNT) begin
			we    = 1'b1;
			waddr = head1_reg[AW-1:0];
			wdata = smb_reg ? stat_byte : cnt_byte;
		end else if (take_byte && !fifo_full && !oversize) begin
			we = 1'b1; // [R9]
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rst_q_reg <= 1'b0;
		end else begin
			rst_q_reg <= receiver_reset;
		end
	end

	always_ff @(posedge clk) begin
		if (srst || rcv_reset) begin
			state_reg <= S_IDLE;
			len_reg   <= 8'h00;
			kind_reg  <= 3'h0;
			smb_reg   <= 1'b0;
		end else begin
			unique case (state_reg)
				S_IDLE: begin
					if (frame_start && hdr_room) begin
						state_reg <= S_DATA;
						len_reg   <= 8'h00;
						kind_reg  <= received_frame_start_kind;
						smb_reg   <= smbus_layout;
					end
				end
				S_DATA: begin
					if (frame_end) begin
						state_reg <= crc_good ? S_COUNT : S_IDLE; // [R13]
					end else if (bus_idle) begin
						state_reg <= S_IDLE; // [R12]
					end else if (take_byte && !fifo_full && !oversize) begin
						len_reg <= len_reg + 8'h01;
					end
				end
				S_COUNT: begin
					state_reg <= S_IDLE;
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Pointers
	// ****************************************
	always_ff @(posedge clk) begin
		if (srst || rcv_reset) begin
			head_reg  <= rxq_pkg::PTR_RESET; // [R20]
			head1_reg <= rxq_pkg::PTR_ONE;
			cur_reg   <= rxq_pkg::PTR_TWO;
			rd_reg    <= rxq_pkg::PTR_RESET;
		end else if (ptr_load) begin
			head_reg  <= ptr_load_head; // [R18]
			head1_reg <= ptr_add(ptr_load_head, rxq_pkg::PTR_ONE);
			cur_reg   <= ptr_load_cur;
			rd_reg    <= ptr_load_rd;
		end else begin
			if (state_reg == S_IDLE && frame_start && hdr_room) begin
				cur_reg <= ptr_add(head_reg, rxq_pkg::PTR_TWO); // [R8] [R15]
			end else if (state_reg == S_DATA && !frame_end && !bus_idle
					&& take_byte && !fifo_full && !oversize) begin
				cur_reg <= ptr_add(cur_reg, rxq_pkg::PTR_ONE); // [R9] [R14]
			end
			if (state_reg == S_COUNT) begin
				head_reg  <= cur_reg; // [R11]
				head1_reg <= ptr_add(cur_reg, rxq_pkg::PTR_ONE);
			end
			if (rd_strobe && !fifo_empty) begin
				rd_reg <= ptr_add(rd_reg, rxq_pkg::PTR_ONE); // [R23]
			end
		end
	end

	// ****************************************
	// RAM and read side
	// ****************************************
	logic [7:0] ram_q;

	rxq_ram #(.AW(AW)) u_ram (
		.clk   (clk),
		.we    (we),
		.waddr (waddr),
		.wdata (wdata),
		.raddr (rd_reg[AW-1:0]),
		.rdata (ram_q)
	);

	// Read data registers the byte under the read pointer, zero when empty.
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_data_reg <= rxq_pkg::STAT_EMPTY;
			ne_reg      <= 1'b0;
		end else begin
			rd_data_reg <= fifo_empty ? rxq_pkg::STAT_EMPTY : ram_q; // [R4] [R1]
			ne_reg      <= !fifo_empty;
		end
	end

	// ****************************************
	// Sticky error flags
	// ****************************************
	logic [3:0] err_set;

	// Bits: 0 overrun, 1 oversize, 2 abnormal end, 3 corrupted.
	always_comb begin
		err_set    = 4'h0;
		err_set[0] = (state_reg == S_IDLE && frame_start && !hdr_room)
			|| (take_byte && fifo_full && !frame_end && !bus_idle); // [R14] [R15]
		err_set[1] = take_byte && !fifo_full && oversize && !frame_end && !bus_idle; // [R16]
		err_set[2] = (state_reg == S_DATA) && !frame_end && bus_idle;
		err_set[3] = (state_reg == S_DATA) && frame_end && !crc_good;
	end

	// A set in the same cycle as a clear wins.
	always_ff @(posedge clk) begin
		if (srst) begin
			err_reg <= 4'h0;
		end else begin
			err_reg <= (err_reg & ~err_clear) | err_set; // [R24]
		end
	end

	assign rd_data   = rd_data_reg;
	assign not_empty = ne_reg;
	assign err_flags = err_reg;
	assign head_ptr  = head_reg;
	assign head1_ptr = head1_reg;
	assign cur_ptr   = cur_reg;
	assign rd_ptr    = rd_reg;

	// ****************************************
	// Checks
	// ****************************************
	a_start_ptr: assert property (@(posedge clk) disable iff (srst) // [R8]
		(state_reg == S_IDLE && frame_start && hdr_room && !ptr_load && !rcv_reset)
		|=> cur_reg == ptr_add($past(head_reg), rxq_pkg::PTR_TWO))
		else $error("write pointer not head plus two at start");
	a_head_commit: assert property (@(posedge clk) disable iff (srst) // [R11]
		(state_reg == S_COUNT && !ptr_load && !rcv_reset) |=> head_reg == $past(cur_reg))
		else $error("head not committed");
	a_drop_bad: assert property (@(posedge clk) disable iff (srst) // [R13]
		(state_reg == S_DATA && frame_end && !crc_good && !rcv_reset) |=> state_reg == S_IDLE
		&& err_reg[3]) else $error("bad packet not dropped");
	a_full_hold: assert property (@(posedge clk) disable iff (srst) // [R14]
		(state_reg == S_DATA && fifo_full && !ptr_load && !rcv_reset) |=> $stable(cur_reg))
		else $error("pointer moved while full");
	a_empty_zero: assert property (@(posedge clk) disable iff (srst) // [R4]
		fifo_empty |=> rd_data_reg == rxq_pkg::STAT_EMPTY) else $error("empty read not zero");
	a_sticky_err: assert property (@(posedge clk) disable iff (srst) // [R24]
		(err_set != 4'h0) |=> (err_reg & $past(err_set)) == $past(err_set))
		else $error("error flag lost");
	a_reset_ptrs: assert property (@(posedge clk) disable iff (srst) // [R20]
		rcv_reset |=> head_reg == rxq_pkg::PTR_RESET && rd_reg == rxq_pkg::PTR_RESET)
		else $error("pointers not reset");
	a_oversize_hold: assert property (@(posedge clk) disable iff (srst) // [R16]
		err_set[1] && !ptr_load && !rcv_reset |=> $stable(cur_reg))
		else $error("pointer moved on oversize");
	c_good_pkt: cover property (@(posedge clk) state_reg == S_COUNT);
	c_overrun: cover property (@(posedge clk) err_set[0]);
	c_read: cover property (@(posedge clk) rd_strobe && !fifo_empty);
	c_no_room: cover property (@(posedge clk) state_reg == S_IDLE && frame_start && !hdr_room);
endmodule : pd_receive_packet_queue
`default_nettype wire

// >>> testbench/rxq_byte_source.sv
// De-serializer model that frames packets and hands their bytes over valid/ready.
`default_nettype none
module rxq_byte_source (
	// Clock.
	input  wire logic       clk,
	// Frame events and bytes towards the queue.
	output logic            frame_start,
	output logic [2:0]      kind,
	output logic            byte_valid,
	input  wire logic       byte_ready,
	output logic [7:0]      byte_data,
	output logic            frame_end,
	output logic            crc_good,
	output logic            bus_idle
);
	timeunit 1ns;
	timeprecision 1ps;
	int timeouts;
	initial begin
		timeouts    = 0;
		frame_start = 1'b0;
		kind        = 3'h0;
		byte_valid  = 1'b0;
		byte_data   = 8'h00;
		frame_end   = 1'b0;
		crc_good    = 1'b0;
		bus_idle    = 1'b0;
	end
	// ****************************************
	// Packet driver
	// ****************************************
	// The ending is 0 for good CRC, 1 for bad CRC, 2 for the line going idle.
	task send(input logic [2:0] k, input int n, input logic [7:0] first, input int how,
		input logic stall);
		int i;
		int w;
		@(negedge clk);
		frame_start = 1'b1;
		kind        = k;
		@(negedge clk);
		frame_start = 1'b0;
		for (i = 0; i < n; i++) begin
			if (stall && i[0]) begin
				byte_valid = 1'b0;
				byte_data  = ~byte_data;
				@(negedge clk);
			end
			byte_valid = 1'b1;
			byte_data  = first + i[7:0];
			w = 0;
			while (byte_ready !== 1'b1 && w < 50) begin
				@(negedge clk);
				w++;
			end
			if (w == 50) begin
				timeouts++;
			end
			@(negedge clk);
		end
		// A released data line does not keep showing the last byte.
		byte_valid = 1'b0;
		byte_data  = ~byte_data;
		repeat (4) @(negedge clk);
		frame_end = (how != 2);
		crc_good  = (how == 0);
		bus_idle  = (how == 2);
		@(negedge clk);
		frame_end = 1'b0;
		crc_good  = 1'b0;
		bus_idle  = 1'b0;
		repeat (5) @(negedge clk);
	endtask : send
endmodule : rxq_byte_source
`default_nettype wire

// >>> testbench/pd_receive_packet_queue_tb_top.sv
// Self-checking bench for the receive packet queue.
`default_nettype none
module pd_receive_packet_queue_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, srst, frame_start, byte_valid, byte_ready, frame_end, crc_good, bus_idle;
	logic [2:0] kind;
	logic [7:0] byte_data, max_packet_size, rd_data, ptr_load_head, ptr_load_cur, ptr_load_rd;
	logic       smbus_layout, receiver_reset, rd_strobe, not_empty, ptr_load;
	logic [7:0] head_ptr, head1_ptr, cur_ptr, rd_ptr, exp_head;
	logic [3:0] err_clear, err_flags;
	int         failures, num_checks, k;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	pd_receive_packet_queue u_dut (.clk(clk), .srst(srst), .frame_start(frame_start),
		.received_frame_start_kind(kind), .byte_valid(byte_valid), .byte_ready(byte_ready),
		.byte_data(byte_data), .frame_end(frame_end), .crc_good(crc_good), .bus_idle(bus_idle),
		.smbus_layout(smbus_layout), .receiver_reset(receiver_reset),
		.max_packet_size(max_packet_size), .rd_strobe(rd_strobe), .rd_data(rd_data),
		.not_empty(not_empty), .ptr_load(ptr_load), .ptr_load_head(ptr_load_head),
		.ptr_load_cur(ptr_load_cur), .ptr_load_rd(ptr_load_rd), .head_ptr(head_ptr),
		.head1_ptr(head1_ptr), .cur_ptr(cur_ptr), .rd_ptr(rd_ptr), .err_clear(err_clear),
		.err_flags(err_flags));
	rxq_byte_source u_src (.clk(clk), .frame_start(frame_start), .kind(kind),
		.byte_valid(byte_valid), .byte_ready(byte_ready), .byte_data(byte_data),
		.frame_end(frame_end), .crc_good(crc_good), .bus_idle(bus_idle));
	// ****************************************
	// Access tasks
	// ****************************************
	task check8(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check8
	// The byte at the read pointer is shown ahead of the strobe that consumes it.
	task rd_byte(output logic [7:0] v);
		repeat (2) @(negedge clk);
		v = rd_data;
		rd_strobe = 1'b1;
		@(negedge clk);
		rd_strobe = 1'b0;
	endtask : rd_byte
	task expect_pkt(input logic [2:0] kd, input logic [7:0] cnt, input logic [7:0] first,
		input logic smb);
		logic [7:0] v;
		logic [7:0] st;
		int i;
		st = {1'b0, kd, 3'h0, 1'b1};
		rd_byte(v);
		check8(v, smb ? cnt + 8'h01 : st);
		rd_byte(v);
		check8(v, smb ? st : cnt);
		for (i = 0; i < cnt; i++) begin
			rd_byte(v);
			check8(v, first + i[7:0]);
		end
	endtask : expect_pkt
	task clear_flags(input logic [3:0] f);
		check8({4'h0, err_flags}, {4'h0, f});
		@(negedge clk);
		err_clear = f;
		@(negedge clk);
		err_clear = 4'h0;
		@(negedge clk);
		check8({4'h0, err_flags}, 8'h00);
	endtask : clear_flags
	task results;
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	initial begin
		#200000;
		failures++;
		results;
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		{srst, smbus_layout, receiver_reset, rd_strobe, ptr_load} = 5'h10;
		{ptr_load_head, ptr_load_cur, ptr_load_rd, err_clear} = 28'h0;
		max_packet_size = 8'hFF;
		failures = 0;
		num_checks = 0;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		check8(head_ptr, 8'h00);
		check8(head1_ptr, 8'h01);
		check8(cur_ptr, 8'h02);
		check8(rd_data, 8'h00);
		check8(rd_ptr, 8'h00);
		check8({7'h00, not_empty}, 8'h00);
		check8({7'h00, byte_ready}, 8'h01);
		exp_head = 8'h00;
		for (k = 0; k < 5; k++) begin
			u_src.send(k[2:0], 6, 8'h10 * k[7:0], 0, k[0]);
			exp_head = exp_head + 8'h08;
			check8(head_ptr, exp_head);
			check8(head1_ptr, exp_head + 8'h01);
			check8({7'h00, not_empty}, 8'h01);
			expect_pkt(k[2:0], 8'h06, 8'h10 * k[7:0], 1'b0);
			repeat (3) @(negedge clk);
			check8(rd_ptr, exp_head);
			check8(rd_data, 8'h00);
			check8({7'h00, not_empty}, 8'h00);
		end
		smbus_layout = 1'b1;
		u_src.send(3'h3, 5, 8'hA0, 0, 1'b0);
		smbus_layout = 1'b0;
		exp_head = exp_head + 8'h07;
		expect_pkt(3'h3, 8'h05, 8'hA0, 1'b1);
		u_src.send(3'h1, 4, 8'h60, 1, 1'b0);
		check8(head_ptr, exp_head);
		check8({7'h00, not_empty}, 8'h00);
		clear_flags(4'h8);
		u_src.send(3'h2, 3, 8'h70, 2, 1'b1);
		check8(head_ptr, exp_head);
		clear_flags(4'h4);
		max_packet_size = 8'h04;
		u_src.send(3'h0, 6, 8'h50, 0, 1'b0);
		max_packet_size = 8'hFF;
		exp_head = exp_head + 8'h06;
		check8(head_ptr, exp_head);
		clear_flags(4'h2);
		expect_pkt(3'h0, 8'h04, 8'h50, 1'b0);
		@(negedge clk);
		{ptr_load_head, ptr_load_cur, ptr_load_rd, ptr_load} = 25'h10B0F0B;
		@(negedge clk);
		ptr_load = 1'b0;
		@(negedge clk);
		check8(head_ptr, 8'h85);
		check8(head1_ptr, 8'h86);
		check8(cur_ptr, 8'h87);
		check8(rd_ptr, 8'h85);
		// 126 data bytes fill the ring behind the two reserved control bytes.
		u_src.send(3'h2, 130, 8'h00, 2, 1'b0);
		check8(cur_ptr, 8'h05);
		clear_flags(4'h5);
		// Head 127 bytes ahead of the read pointer leaves no room for the control bytes.
		@(negedge clk);
		{ptr_load_head, ptr_load_cur, ptr_load_rd, ptr_load} = 25'h008090B;
		@(negedge clk);
		ptr_load = 1'b0;
		u_src.send(3'h1, 2, 8'h30, 0, 1'b0);
		check8(cur_ptr, 8'h04);
		check8(head_ptr, 8'h04);
		clear_flags(4'h1);
		@(negedge clk);
		receiver_reset = 1'b1;
		@(negedge clk);
		receiver_reset = 1'b0;
		repeat (2) @(negedge clk);
		check8(head_ptr, 8'h00);
		check8(head1_ptr, 8'h01);
		check8(cur_ptr, 8'h02);
		check8(rd_ptr, 8'h00);
		check8(u_src.timeouts[7:0], 8'h00);
		results;
	end
endmodule : pd_receive_packet_queue_tb_top
`default_nettype wire
